// ### design/rsc_core.sv
`default_nettype none
module rsc_core
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fetch side: word held stable from Q1 through Q4
  input wire logic insn_valid,
  input wire logic [rsc_pkg::INSN_W-1:0] insn_word,
  input wire logic [rsc_pkg::PC_W-1:0] program_counter,
  // Return stack strobes, one clock each
  output logic stack_push,
  output logic stack_pop,
  output logic [rsc_pkg::PC_W-1:0] stack_top_entry,
  // Program counter load
  output logic pc_load,
  output logic [rsc_pkg::PC_W-1:0] pc_target,
  // Fetch stall for the second cycle of a call
  output logic insn_busy,
  // Software master clear request
  output logic sw_master_clear,
  // Phase
  output logic [1:0] q_phase
);
  import rsc_pkg::*;

  rsc_phase_t phase;
  logic push_q;
  logic pop_q;
  logic [PC_W-1:0] top_q;
  logic pcl_q;
  logic [PC_W-1:0] tgt_q;
  logic busy_q;
  logic clr_q;
  logic [1:0] ph_q;

  // Phase runs free from reset with no resync: the fetch must present
  // each word on a Q1 edge, or every strobe lands in the wrong quarter
  rsc_phase_gen u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase(phase)
  );

  function automatic logic is_call(input logic [INSN_W-1:0] w);
    is_call = (w[15:11] == OP_RELATIVE_SUBROUTINE_CALL_HI);
  endfunction : is_call

  // Decode only while not in the dead cycle of a call
  wire live = insn_valid && !busy_q;
  wire dec_pop = live && (insn_word == OP_DISCARD);
  wire dec_push = live && (insn_word == OP_PUSH);
  wire dec_call = live && is_call(insn_word);
  wire dec_clr = live && (insn_word == OP_SWRESET);
  wire [PC_W-1:0] ret_addr = program_counter + PC_STEP;
  // Offset doubled and sign extended keeps word alignment
  wire [PC_W-1:0] ofs2 = {{(PC_W-OFS_W-1){insn_word[OFS_W-1]}},
                          insn_word[OFS_W-1:0], 1'b0};
  wire [PC_W-1:0] call_tgt = ret_addr + ofs2;
  wire in_q2 = (phase == RSC_Q2);
  wire in_q3 = (phase == RSC_Q3);
  wire in_q4 = (phase == RSC_Q4);
  // Flags are untouched: this block drives no status path
  wire push_d = in_q2 && (dec_push || dec_call);
  wire pop_d = in_q3 && dec_pop;
  wire pcl_d = in_q4 && dec_call;
  wire clr_d = in_q2 && dec_clr;
  // Busy spans the whole second cycle of a call
  wire busy_d = in_q4 ? dec_call : busy_q;

  // Strobes last the one clock after their phase edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      push_q <= 1'b0;
      pop_q <= 1'b0;
      pcl_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      push_q <= push_d;
      pop_q <= pop_d;
      pcl_q <= pcl_d;
      clr_q <= clr_d;
    end
  end

  // Addresses track the fetch every clock; only a strobe gives them weight
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      top_q <= PC_RESET;
      tgt_q <= PC_RESET;
    end
    else
    begin
      top_q <= ret_addr;
      tgt_q <= call_tgt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ph_q <= RSC_Q1;
      busy_q <= 1'b0;
    end
    else
    begin
      ph_q <= phase;
      busy_q <= busy_d;
    end
  end
  // Depth limits are the stack pointer's job, not handled here.

  assign stack_push = push_q;
  assign stack_pop = pop_q;
  assign stack_top_entry = top_q;
  assign pc_load = pcl_q;
  assign pc_target = tgt_q;
  assign insn_busy = busy_q;
  assign sw_master_clear = clr_q;
  assign q_phase = ph_q;

  a_push_phase: assert property (@(posedge clk) disable iff (sys_rst)
    stack_push |-> $past(phase) == RSC_Q2)
    else $error("push outside Q2");
  a_pop_phase: assert property (@(posedge clk) disable iff (sys_rst)
    stack_pop |-> $past(phase) == RSC_Q3)
    else $error("pop outside Q3");
  a_push_value: assert property (@(posedge clk) disable iff (sys_rst)
    stack_push |-> stack_top_entry == $past(program_counter) + PC_STEP)
    else $error("push value not pc plus 2");
  a_call_order: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> $past(stack_push, 2))
    else $error("pc loaded without prior push");
  a_call_busy: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> insn_busy [*4])
    else $error("call second cycle missing");
  a_pop_decode: assert property (@(posedge clk) disable iff (sys_rst)
    stack_pop |-> $past(insn_word) == OP_DISCARD)
    else $error("pop without discard opcode");
  a_clr_decode: assert property (@(posedge clk) disable iff (sys_rst)
    sw_master_clear |-> $past(insn_word) == OP_SWRESET)
    else $error("reset without opcode");
  a_clr_phase: assert property (@(posedge clk) disable iff (sys_rst)
    sw_master_clear |-> $past(phase) == RSC_Q2)
    else $error("reset not in Q2");
  a_call_decode: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> $past(insn_word[15:11]) == OP_RELATIVE_SUBROUTINE_CALL_HI)
    else $error("pc load without call opcode");
  a_push_decode: assert property (@(posedge clk) disable iff (sys_rst)
    stack_push |-> $past(insn_word) == OP_PUSH
      || $past(insn_word[15:11]) == OP_RELATIVE_SUBROUTINE_CALL_HI)
    else $error("push without opcode");
  a_call_target: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> pc_target == $past(program_counter) + PC_STEP
      + {{9{$past(insn_word[10])}}, $past(insn_word[10:0]), 1'b0})
    else $error("call target wrong");

  // Strobes are one-clock pulses, one per instruction at most
  a_push_gap: assert property (@(posedge clk) disable iff (sys_rst)
    stack_push |=> (!stack_push) [*3])
    else $error("push repeated within one instruction");
  a_pop_gap: assert property (@(posedge clk) disable iff (sys_rst)
    stack_pop |=> (!stack_pop) [*3])
    else $error("pop repeated within one instruction");
  a_clr_gap: assert property (@(posedge clk) disable iff (sys_rst)
    sw_master_clear |=> (!sw_master_clear) [*3])
    else $error("reset request longer than one clock");
  a_load_gap: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |=> (!pc_load) [*7])
    else $error("pc loaded twice within one call");

  // One strobe per edge keeps push and pop apart at the stack
  a_strobe_alone: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot0({stack_push, stack_pop, pc_load, sw_master_clear}))
    else $error("strobes overlap");
  a_load_phase: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> $past(phase) == RSC_Q4)
    else $error("pc load outside Q4");
  a_target_even: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> pc_target[0] == $past(program_counter[0]))
    else $error("call target lost word alignment");
  a_call_follow: assert property (@(posedge clk) disable iff (sys_rst)
    stack_push && $past(insn_word[15:11]) == OP_RELATIVE_SUBROUTINE_CALL_HI |-> ##2 pc_load)
    else $error("call push not followed by pc load");
  a_push_nojump: assert property (@(posedge clk) disable iff (sys_rst)
    stack_push && $past(insn_word) == OP_PUSH |-> ##2 !pc_load)
    else $error("plain push moved the pc");

  // Dead cycle: busy rises with the load, lasts four clocks, then drops
  a_busy_rise: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(insn_busy) |-> pc_load)
    else $error("busy without pc load");
  a_busy_ends: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |=> insn_busy [*3] ##1 !insn_busy)
    else $error("busy not released after call");
  a_busy_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    insn_busy |-> !stack_push && !stack_pop && !sw_master_clear)
    else $error("strobe during dead cycle");

  // An absent fetch word must leave the stack and the pc alone
  a_valid_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(insn_valid)
      |-> !stack_push && !stack_pop && !pc_load && !sw_master_clear)
    else $error("strobe without valid word");

  // A skipped phase would misplace every strobe
  a_phase_next: assert property (@(posedge clk) disable iff (sys_rst)
    phase == RSC_Q2 |=> phase == RSC_Q3)
    else $error("phase did not advance from Q2");
  a_phase_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    phase == RSC_Q4 |=> phase == RSC_Q1)
    else $error("phase did not wrap after Q4");
endmodule : rsc_core
`default_nettype wire

// ### design/rsc_pkg.sv
// Summary of operation
// - Opcode 0006h discards stack top entry
// - Discard is single cycle, done in Q3
// - Opcode 0005h pushes, flags unchanged
// - Push writes program counter plus 2
// - Push in Q2; software stack possible
// - Call opcode 11011 with signed 11-bit offset
// - Call pushes return address before jumping
// - Call target is pc plus 2 plus 2n
// - Call takes two cycles; pc written Q4
// - Opcode 00ffh requests software master clear
// - Software reset starts in Q2
`default_nettype none
package rsc_pkg;
  localparam int PC_W = 21;
  localparam int INSN_W = 16;
  localparam logic [15:0] OP_DISCARD = 16'h0006;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_SWRESET = 16'h00ff;
  localparam logic [4:0] OP_RELATIVE_SUBROUTINE_CALL_HI = 5'h1b;
  localparam int OFS_W = 11;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  typedef enum logic [1:0] {
    RSC_Q1 = 2'b00,
    RSC_Q2 = 2'b01,
    RSC_Q3 = 2'b11,
    RSC_Q4 = 2'b10
  } rsc_phase_t;
endpackage : rsc_pkg
`default_nettype wire

// ### design/rsc_phase_gen.sv
`default_nettype none
module rsc_phase_gen
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Phase
  output rsc_phase_t phase
);
  rsc_phase_t phase_q;
  rsc_phase_t phase_d;
  // Gray order keeps one bit changing per step
  always_comb
  begin
    case (phase_q)
      RSC_Q1: phase_d = RSC_Q2;
      RSC_Q2: phase_d = RSC_Q3;
      RSC_Q3: phase_d = RSC_Q4;
      default: phase_d = RSC_Q1;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      phase_q <= RSC_Q1;
    else
      phase_q <= phase_d;
  end
  assign phase = phase_q;
endmodule : rsc_phase_gen
`default_nettype wire

// ### testbench/rsc_stack_model.sv
`default_nettype none
module rsc_stack_model
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Strobes from the core
  input wire logic push,
  input wire logic pop,
  input wire logic [rsc_pkg::PC_W-1:0] din,
  // Top entry
  output logic [rsc_pkg::PC_W-1:0] top
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PC_W-1:0] mem_q [8];
  logic [2:0] sp_q;
  // Pointer wraps silently; the core leaves depth limits to the stack pointer
  assign top = mem_q[sp_q];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sp_q <= 3'h0;
    else if (push)
    begin
      sp_q <= sp_q + 3'h1;
      mem_q[sp_q + 3'h1] <= din;
    end
    else if (pop)
      sp_q <= sp_q - 3'h1;
  end
endmodule : rsc_stack_model
`default_nettype wire

// ### testbench/return_stack_call_reset_ops_tb.sv
`default_nettype none
module return_stack_call_reset_ops_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rsc_pkg::*;
  logic clk, sys_rst, insn_valid, push, pop, load, busy, clr;
  logic [15:0] insn_word, st, w, k;
  logic [PC_W-1:0] pc, top_e, tgt, top, vt, vg;
  logic [1:0] qp;
  int err_count, checked, cyc, seed;
  rsc_core dut (.clk, .sys_rst, .insn_valid, .insn_word,
    .program_counter(pc), .stack_push(push), .stack_pop(pop),
    .stack_top_entry(top_e), .pc_load(load), .pc_target(tgt),
    .insn_busy(busy), .sw_master_clear(clr), .q_phase(qp));
  rsc_stack_model stk (.clk, .sys_rst, .push, .pop, .din(top_e), .top);
  task automatic tally_and_finish;
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  // Falling edge, counted from the instruction's start, of each strobe
  function automatic logic [15:0] stamps(input logic [15:0] x);
    logic c;
    c = x[15:11] == OP_RELATIVE_SUBROUTINE_CALL_HI;
    stamps = {(c || x == OP_PUSH) ? 4'h2 : 4'h0,
      x == OP_DISCARD ? 4'h3 : 4'h0, c ? 4'h4 : 4'h0,
      x == OP_SWRESET ? 4'h2 : 4'h0};
  endfunction : stamps
  // Phase that q_phase shows at the i-th falling edge of an instruction
  function automatic logic [1:0] qcode(input int i);
    case ((i - 1) % 4)
      0: qcode = RSC_Q1;
      1: qcode = RSC_Q2;
      2: qcode = RSC_Q3;
      default: qcode = RSC_Q4;
    endcase
  endfunction : qcode
  task automatic run(input logic [15:0] x, input logic [PC_W-1:0] p,
    input logic v);
    int n;
    logic c;
    c = v && x[15:11] == OP_RELATIVE_SUBROUTINE_CALL_HI;
    n = c ? 8 : 4;
    insn_word = x;
    pc = p;
    insn_valid = v;
    st = 16'h0;
    for (int i = 1; i <= n; i++)
    begin
      @(negedge clk);
      if (push)
      begin
        st[15:12] = 4'(i);
        vt = top_e;
      end
      if (pop)
        st[11:8] = 4'(i);
      if (load)
      begin
        st[7:4] = 4'(i);
        vg = tgt;
      end
      if (clr)
        st[3:0] = 4'(i);
      chk(qp, qcode(i));
      chk(busy, c && i >= 4 && i < 8);
      // A word offered during the dead cycle must be ignored
      if (c && i == 4)
        insn_word = OP_PUSH;
    end
    chk(st, v ? stamps(x) : 16'h0);
    if (st[15:12] != 4'h0)
      chk(vt, PC_W'(p + PC_STEP));
    if (st[7:4] != 4'h0)
      chk(vg, PC_W'(p + PC_STEP + {{9{x[10]}}, x[10:0], 1'b0}));
  endtask : run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    seed = 32'h2b9ede70;
    sys_rst = 1'b1;
    insn_valid = 1'b0;
    insn_word = 16'h0;
    pc = 21'h0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    run(OP_PUSH, 21'h000124, 1'b1);
    run(OP_PUSH, 21'h1ffffe, 1'b1);
    run(OP_DISCARD, 21'h000040, 1'b1);
    run(16'h0000, 21'h0, 1'b1);
    chk(top, 21'h000126);
    run(16'hdc00, 21'h000100, 1'b1);
    run(16'hdbff, 21'h1ff000, 1'b1);
    run(OP_PUSH, 21'h000300, 1'b0);
    run(OP_SWRESET, 21'h000200, 1'b1);
    // Reset controller answers the request: all quiet, phase back to Q1
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    chk({push, pop, load, busy, clr, qp}, 32'h0);
    chk(top_e, PC_RESET);
    sys_rst = 1'b0;
    for (int j = 0; j < 150; j++)
    begin
      w = $random(seed);
      k = $random(seed);
      if (k[1])
        w[15:11] = OP_RELATIVE_SUBROUTINE_CALL_HI;
      else if (k[2])
        w = k[3] ? OP_PUSH : (k[4] ? OP_DISCARD : OP_SWRESET);
      run(w, {k[4:0], w} << 1, k[5] || k[6]);
    end
    tally_and_finish;
  end
endmodule : return_stack_call_reset_ops_tb
`default_nettype wire
